/* File: psc_pkg.sv */
`default_nettype none

package psc_pkg;

	// Power-up reset time in microseconds and derived cycle count
	localparam int unsigned POWERUP_RESET_TIME_US = 45;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned POWERUP_RESET_CYCLES =
		POWERUP_RESET_TIME_US * CLK_MHZ;
	// Clock valid delay in ns and derived cycles (rounded up)
	localparam int unsigned CLOCK_VALID_DELAY_NS = 100;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CLOCK_VALID_CYCLES =
		(CLOCK_VALID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Macrocell register count and signature size
	localparam int unsigned NUM_MACROCELLS = 16;
	localparam int unsigned SIG_BYTES      = 16;

	// Register byte offsets on the Wishbone bus
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_PRELOAD = 8'h08;
	localparam logic [7:0] OFS_REGS    = 8'h0C;
	localparam logic [7:0] OFS_POLAR   = 8'h10;
	localparam logic [7:0] OFS_NEXT    = 8'h14;
	localparam logic [7:0] OFS_SIG     = 8'h40;

	// Control register bit positions
	localparam int unsigned CTRL_TEST_MODE   = 0;
	localparam int unsigned CTRL_DO_PRELOAD  = 1;
	localparam int unsigned CTRL_SET_SECURE  = 2;
	localparam int unsigned CTRL_BULK_ERASE  = 3;
	localparam int unsigned CTRL_RUN_CLOCK   = 4;

	// Key that must be written to control byte 1 (bits 15:8) in test mode
	localparam logic [7:0] TEST_KEY = 8'hA5;

	// Reset values, and the value bulk erase writes to the signature memory
	localparam logic [15:0] REGS_RESET  = 16'h0000;
	localparam logic [15:0] POLAR_RESET = 16'h0000;
	localparam logic [7:0]  SIG_RESET   = 8'hFF;

endpackage : psc_pkg

`default_nettype wire

/* File: psc_por_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// Counts the power-up reset and clock-valid intervals after reset release
module psc_por_timer #(
	parameter int unsigned RESET_CYCLES = psc_pkg::POWERUP_RESET_CYCLES
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Status
	output logic      por_active_o,
	output logic      clock_ok_o
);

	localparam int unsigned TOTAL = RESET_CYCLES
		+ psc_pkg::CLOCK_VALID_CYCLES;

	// Cycle counter since reset release
	logic [15:0] cnt_q;

	// Count up to the end of both intervals, then stop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cnt_q <= 16'h0000;
		else if (cnt_q != TOTAL[15:0])
			cnt_q <= cnt_q + 16'h0001;
	end

	// Reset phase ends after the power-up reset time
	assign por_active_o = rst_i || (cnt_q < RESET_CYCLES[15:0]);
	// Clocking allowed after the clock valid delay too
	assign clock_ok_o   = !rst_i && (cnt_q == TOTAL[15:0]);

endmodule : psc_por_timer

`default_nettype wire

/* File: psc_top.sv */
// What this block does
// - Power-up reset clears every macrocell register within 45us
// - Enabled registered outputs low after reset, any polarity
// - Preload forces any value into macrocell registers
// - Preload only reachable from test equipment
// - Sixteen byte signature memory, verify readback only
// - Security cell blocks programming and verify readout, except signature readback
// - Only bulk erase clears the security cell
// - Static select chooses setup or clock-to-output option
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module psc_top #(
	parameter int unsigned RESET_CYCLES = psc_pkg::POWERUP_RESET_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	// Macrocell interface
	input  wire logic [15:0] next_state_i,
	input  wire logic [15:0] out_enable_i,
	input  wire logic        timing_option_select_i,
	output logic      [15:0] reg_q_o,
	output logic      [15:0] pin_o,
	output logic      [15:0] pin_oe_o,
	output logic             late_capture_o,
	output logic             por_active_o
);

	// Power-up timing
	logic        por_active;
	logic        clock_ok;
	// Timing select synchroniser
	logic        sel_meta_q;
	logic        sel_sync_q;
	// Next state synchroniser (pins)
	logic [15:0] ns_meta_q;
	logic [15:0] ns_sync_q;
	logic [15:0] oe_meta_q;
	logic [15:0] oe_sync_q;
	// Macrocell registers and programmed polarity
	logic [15:0] regs_q;
	logic [15:0] polar_q;
	// Staging value for preload
	logic [15:0] preload_q;
	// Control state
	logic        test_mode_q;
	logic        run_clock_q;
	logic        secure_q;
	// Signature memory
	logic [7:0]  sig_mem [psc_pkg::SIG_BYTES];
	// Bus decode
	logic        req;
	logic        wr;
	logic        rd;
	logic        hit;
	logic [31:0] rdata_d;
	logic        sig_hit;
	logic [3:0]  sig_idx;
	logic        ctrl_wr;   // Control register write, low byte present
	logic        cmd_wr;    // Command write accepted only in test mode
	logic        regs_run;  // Functional clock edge for the macrocells
	// Byte-merged write values for the 16-bit registers
	logic [31:0] preload_m;
	logic [31:0] polar_m;

	// Power-up reset timer
	// Restarts on every reset, so a mid-run reset clears again
	psc_por_timer #(
		.RESET_CYCLES(RESET_CYCLES)
	) u_por (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.por_active_o(por_active),
		.clock_ok_o  (clock_ok)
	);

	// Byte merge for Wishbone writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	// Control write decode, shared by every command process
	function automatic logic ctrl_write(input logic w,
		input logic [7:0] a, input logic [3:0] s);
		return w && (a == psc_pkg::OFS_CTRL) && s[0];
	endfunction : ctrl_write

	// Request decode
	assign req     = cyc_i && stb_i && !ack_o && !err_o;
	assign wr      = req && we_i && hit;
	assign rd      = req && !we_i;
	assign sig_hit = (adr_i >= psc_pkg::OFS_SIG)
		&& (adr_i < psc_pkg::OFS_SIG + 8'h40) && (adr_i[1:0] == 2'b00);
	assign sig_idx = adr_i[5:2];
	// Command strobes; commands need test mode entered beforehand
	assign ctrl_wr   = ctrl_write(wr, adr_i, sel_i);
	assign cmd_wr    = ctrl_wr && test_mode_q;
	// Functional clocking only after the clock valid delay
	assign regs_run  = clock_ok && run_clock_q && !test_mode_q;
	// Merged write data for the staging and polarity registers
	assign preload_m = merge({16'h0000, preload_q}, dat_i, sel_i);
	assign polar_m   = merge({16'h0000, polar_q}, dat_i, sel_i);

	// Address map check
	always_comb
	begin
		case (adr_i)
			psc_pkg::OFS_CTRL, psc_pkg::OFS_STATUS,
			psc_pkg::OFS_PRELOAD, psc_pkg::OFS_REGS,
			psc_pkg::OFS_POLAR, psc_pkg::OFS_NEXT:
				hit = 1'b1;
			default:
				hit = sig_hit;
		endcase
	end

	// Synchronise pin inputs
	always_ff @(posedge clk_i)
	begin
		// Two flops before any logic reads a pin
		sel_meta_q <= timing_option_select_i;
		sel_sync_q <= sel_meta_q;
		ns_meta_q  <= next_state_i;
		ns_sync_q  <= ns_meta_q;
		oe_meta_q  <= out_enable_i;
		oe_sync_q  <= oe_meta_q;
	end

	// Test mode entered only with key, left on any control write without bit 0 and the key
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			test_mode_q <= 1'b0;
		else if (ctrl_wr)
			// Key byte guards against accidental entry
			test_mode_q <= dat_i[psc_pkg::CTRL_TEST_MODE]
				&& sel_i[1] && dat_i[15:8] == psc_pkg::TEST_KEY;
	end

	// Functional clock run enable
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			run_clock_q <= 1'b0;
		else if (ctrl_wr)
			// Takes effect only after the clock valid delay
			run_clock_q <= dat_i[psc_pkg::CTRL_RUN_CLOCK];
	end

	// Security cell: set by command, cleared only by bulk erase
	always_ff @(posedge clk_i)
	begin
		if (cmd_wr)
		begin
			// Erase wins over set in one write
			if (dat_i[psc_pkg::CTRL_BULK_ERASE])
				secure_q <= 1'b0;
			else if (dat_i[psc_pkg::CTRL_SET_SECURE])
				secure_q <= 1'b1;
		end
		else if (rst_i && secure_q !== 1'b1)
			// Nonvolatile in spirit; only defined on first reset
			secure_q <= 1'b0;
	end

	// Preload staging value
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			preload_q <= psc_pkg::REGS_RESET;
		else if (wr && adr_i == psc_pkg::OFS_PRELOAD)
			// Staging is free to write; only a command applies it
			preload_q <= preload_m[15:0];
	end

	// Output polarity configuration, programmable unless secured
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			polar_q <= psc_pkg::POLAR_RESET;
		else if (wr && adr_i == psc_pkg::OFS_POLAR && test_mode_q
			&& !secure_q)
			// Part of the protected configuration
			polar_q <= polar_m[15:0];
	end

	// Signature memory: writable when programming is allowed
	always_ff @(posedge clk_i)
	begin
		// Locked once the security cell is set
		if (wr && sig_hit && test_mode_q && !secure_q && sel_i[0])
			sig_mem[sig_idx] <= dat_i[7:0];
		else if (cmd_wr && dat_i[psc_pkg::CTRL_BULK_ERASE])
			// Bulk erase wipes the whole signature memory
			for (int i = 0; i < psc_pkg::SIG_BYTES; i++)
				sig_mem[i] <= psc_pkg::SIG_RESET;
	end

	// Macrocell registers: reset, preload, or functional clock
	always_ff @(posedge clk_i)
	begin
		if (por_active)
			regs_q <= psc_pkg::REGS_RESET;
		else if (cmd_wr && dat_i[psc_pkg::CTRL_DO_PRELOAD])
			// Any value, reachable or not, for test vectors
			regs_q <= preload_q;
		else if (regs_run)
			// Normal sequencing from the synchronised pins
			regs_q <= ns_sync_q;
	end

	// Read mux
	always_comb
	begin
		// Refused reads return zero; unmapped reads get err and leave dat_o as it was
		rdata_d = 32'h0000_0000;
		case (adr_i)
			psc_pkg::OFS_CTRL:
				rdata_d = {27'h0, run_clock_q, 1'b0, secure_q, 1'b0,
					test_mode_q};
			psc_pkg::OFS_STATUS:
				rdata_d = {28'h0, sel_sync_q, clock_ok, por_active,
					secure_q};
			psc_pkg::OFS_PRELOAD:
				rdata_d = {16'h0000, preload_q};
			psc_pkg::OFS_REGS:
				// Verify readout blocked by security cell
				rdata_d = (test_mode_q && !secure_q) ?
					{16'h0000, regs_q} : 32'h0000_0000;
			psc_pkg::OFS_POLAR:
				rdata_d = (test_mode_q && !secure_q) ?
					{16'h0000, polar_q} : 32'h0000_0000;
			psc_pkg::OFS_NEXT:
				rdata_d = {16'h0000, ns_sync_q};
			default:
				// Signature readable only by verify in test mode
				if (sig_hit && test_mode_q)
					rdata_d = {24'h000000, sig_mem[sig_idx]};
		endcase
	end

	// Bus answer: one cycle after request, error on unmapped
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			// A held request is masked for the cycle after
			ack_o <= req && hit;
			err_o <= req && !hit;
			if (rd && hit)
				dat_o <= rdata_d;
		end
	end

	// Pins: low after reset regardless of polarity
	always_ff @(posedge clk_i)
	begin
		if (por_active)
			// Low whatever polarity is programmed
			pin_o <= 16'h0000;
		else
			// Idle registers keep the pins low until clocking starts
			pin_o <= (regs_q == 16'h0000 && !run_clock_q) ?
				16'h0000 : regs_q ^ polar_q;
	end

	// Outputs
	assign pin_oe_o       = oe_sync_q;
	assign reg_q_o        = regs_q;
	assign late_capture_o = sel_sync_q;
	assign por_active_o   = por_active;

endmodule : psc_top

`default_nettype wire

/* File: psc_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus answer, power-up and pin-follow checks on the top ports
module psc_checker #(
	parameter int unsigned RESET_CYCLES = 20
) (
	// Clock, reset and bus
	input wire logic        clk_i, rst_i, cyc_i, stb_i, ack_o, err_o,
	input wire logic [7:0]  adr_i,
	// Macrocell side
	input wire logic        por_active_o, timing_option_select_i,
	input wire logic        late_capture_o,
	input wire logic [15:0] out_enable_i, reg_q_o, pin_o, pin_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic        req;       // New request taken at this edge
	logic [15:0] por_cnt_q; // Cycles spent in power-up reset
	assign req = cyc_i && stb_i && !ack_o && !err_o;
	// Count the power-up interval
	always_ff @(posedge clk_i)
		if (rst_i || !por_active_o) por_cnt_q <= 16'h0000;
		else por_cnt_q <= por_cnt_q + 16'h0001;
	a_ack_delay: assert property (req |=> ack_o || err_o)
		else $error("bus answer late");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	a_sig_mapped: assert property (
		req && adr_i[7:6] == 2'b01 && adr_i[1:0] == 2'b00 |=> ack_o)
		else $error("signature word refused");
	a_unmapped_err: assert property (req && adr_i[7] |=> err_o && !ack_o)
		else $error("unmapped access not refused");
	a_por_regs_low: assert property (
		por_active_o |-> reg_q_o == 16'h0000 && pin_o == 16'h0000)
		else $error("register moved during power-up");
	a_por_bound: assert property (por_cnt_q <= RESET_CYCLES + 2)
		else $error("power-up interval too long");
	a_pins_low_after: assert property (
		$fell(por_active_o) |-> pin_o == 16'h0000 && reg_q_o == 16'h0000)
		else $error("pins not low after power-up");
	a_oe_follow: assert property (
		$stable(out_enable_i)[*5] |-> pin_oe_o == out_enable_i)
		else $error("pin enable not following input");
	a_select_follow: assert property (
		$stable(timing_option_select_i)[*5]
		|-> late_capture_o == timing_option_select_i)
		else $error("timing option not following select");
	c_por_done: cover property ($fell(por_active_o));
	c_err: cover property (err_o);
	c_sig: cover property (ack_o && adr_i[6]);
endmodule : psc_checker
bind psc_top psc_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.clk_i,
	.rst_i, .cyc_i, .stb_i, .ack_o, .err_o, .adr_i, .por_active_o,
	.timing_option_select_i, .late_capture_o, .out_enable_i, .reg_q_o,
	.pin_o, .pin_oe_o);
`default_nettype wire

/* File: psc_sys_model.sv */
`timescale 1ns/1ps
`default_nettype none
// System side: pins held still until the clock is declared valid
module psc_sys_model (
	input wire logic         clk_i, rst_i, go_i,
	output logic      [15:0] next_state_o, out_enable_o
);
	always_ff @(posedge clk_i)
		if (rst_i || !go_i)
		begin
			next_state_o <= 16'h0000;
			out_enable_o <= 16'h0000;
		end
		else
		begin
			next_state_o <= next_state_o + 16'h1111;
			out_enable_o <= 16'hF0F0;
		end
endmodule : psc_sys_model
`default_nettype wire

/* File: psc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module psc_top_tb_top;
	localparam int unsigned RC = 20; // Shortened power-up interval
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0;
	logic        tos = 0, ack_o, err_o, late_capture_o, por_active_o, rerr;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, dat_o, rd;
	logic [15:0] ns, oe, reg_q_o, pin_o, pin_oe_o;
	logic [15:0] snap;        // Register value sampled while running
	logic [3:0]  sel = 4'hF;  // Byte selects of the current request
	int          err_total = 0, checks_done = 0, n;
	initial forever #5 clk_i = ~clk_i;
	psc_sys_model u_sys (.clk_i, .rst_i, .go_i(go), .next_state_o(ns),
		.out_enable_o(oe));
	psc_top #(.RESET_CYCLES(RC)) DUT (.clk_i, .rst_i, .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o, .ack_o, .err_o, .next_state_i(ns), .out_enable_i(oe),
		.timing_option_select_i(tos), .reg_q_o, .pin_o, .pin_oe_o,
		.late_capture_o, .por_active_o);
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One classic Wishbone cycle, held until ack or err
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s = 4'hF);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= s;
		wdat <= d;
		n = 0;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 40)
		begin
			@(posedge clk_i);
			n++;
		end
		rd   = dat_o;
		rerr = err_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("wb_answer", 32'h1, {31'h0, n < 40});
	endtask : wb
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e, m);
		wb(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask : rdc
	// Reset, then wait out the power-up and clock-valid intervals
	task automatic do_reset;
		go    <= 1'b0;
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("regs_pins_por", 32'h0, {reg_q_o, pin_o});
		n = 0;
		while (por_active_o !== 1'b0 && n < RC + 20)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("por_len", 32'h1, {31'h0, n <= RC + 2});
		repeat (10) @(posedge clk_i);
		go <= 1'b1;
	endtask : do_reset
	task automatic finish_test;
		$display("Checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	// Watchdog: the whole run needs well under two thousand cycles
	initial
	begin
		#100us;
		err_total++;
		finish_test;
	end
	initial
	begin
		do_reset;
		rdc("sig_hidden", psc_pkg::OFS_SIG, 32'h0, 32'hFF);
		wb(1'b1, psc_pkg::OFS_PRELOAD, 32'h0000BEEF);
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h00000002);
		chk("preload_refused", 32'h0, {16'h0, reg_q_o});
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h0000A501, 4'h1);
		rdc("key_byte", psc_pkg::OFS_CTRL, 32'h0, 32'h1);
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h0000A501);
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h0000A509);
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h00000000);
		wb(1'b1, psc_pkg::OFS_SIG, 32'h00);
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h0000A501);
		rdc("sig_refused", psc_pkg::OFS_SIG, 32'hFF, 32'hFF);
		wb(1'b1, psc_pkg::OFS_POLAR, 32'h000000FF);
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h0000A503);
		repeat (2) @(posedge clk_i);
		chk("preload", 32'hBEEF, {16'h0, reg_q_o});
		chk("pin_polarity", 32'hBE10, {16'h0, pin_o});
		rdc("regs", psc_pkg::OFS_REGS, 32'hBEEF, 32'hFFFF);
		wb(1'b1, 8'h7C, 32'h5A);
		rdc("sig_last", 8'h7C, 32'h5A, 32'hFF);
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h0000A505);
		rdc("secure", psc_pkg::OFS_STATUS, 32'h1, 32'h1);
		rdc("regs_hidden", psc_pkg::OFS_REGS, 32'h0, 32'hFFFF);
		wb(1'b1, psc_pkg::OFS_SIG, 32'h11);
		rdc("sig_guard", psc_pkg::OFS_SIG, 32'hFF, 32'hFF);
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h00000010);
		repeat (4) @(posedge clk_i);
		snap = reg_q_o;
		@(posedge clk_i);
		chk("regs_run", {16'h0, snap + 16'h1111}, {16'h0, reg_q_o});
		chk("pin_run", {16'h0, snap ^ 16'h00FF}, {16'h0, pin_o});
		wb(1'b0, 8'h80, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, rerr});
		tos <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("select", 32'h1, {31'h0, late_capture_o});
		do_reset;
		rdc("secure_kept", psc_pkg::OFS_STATUS, 32'h1, 32'h1);
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h0000A501);
		wb(1'b1, psc_pkg::OFS_CTRL, 32'h0000A509);
		rdc("erased", psc_pkg::OFS_STATUS, 32'h0, 32'h1);
		rdc("sig_erased", 8'h7C, 32'hFF, 32'hFF);
		finish_test;
	end
endmodule : psc_top_tb_top
`default_nettype wire
